// ===== include/siopm_defines.svh
`ifndef SIOPM_DEFINES_SVH
`define SIOPM_DEFINES_SVH
`define SIOPM_NUM_PORTS 3
`define SIOPM_PORT_W 16
`define SIOPM_PORT_STRIDE 8'h20
`define SIOPM_OFF_OUTPUT_VALUE 8'h00
`define SIOPM_OFF_PIN_READBACK 8'h04
`define SIOPM_OFF_DIRECTION 8'h08
`define SIOPM_OFF_PIN_MODE 8'h0c
`define SIOPM_OFF_SELECT_LOW 8'h10
`define SIOPM_OFF_SELECT_HIGH 8'h14
`define SIOPM_RESET_VALUE 16'h0000
`define SIOPM_ADDR_W 8
`endif

// ===== include/siopm_pkg.sv
package siopm_pkg;
  typedef enum logic [1:0] {
    SIOPM_SEL_FIXED = 2'b00,
    SIOPM_SEL_ALT = 2'b01,
    SIOPM_SEL_QUEUE0 = 2'b10,
    SIOPM_SEL_QUEUE1 = 2'b11
  } siopm_sel_e;
  typedef struct packed {
    logic [15:0] output_value;
    logic [15:0] direction;
    logic [15:0] pin_mode;
    logic [15:0] select_low;
    logic [15:0] select_high;
  } siopm_port_cfg_s;
  typedef struct packed {
    logic [15:0] first_queue_word;
    logic [15:0] second_queue_word;
    logic first_queue_empty_flag;
    logic second_queue_empty_flag;
    logic [15:0] modulator_phases;
    logic [5:0] counter_outputs;
    logic [3:0] rate_generator_outputs;
    logic strobe_one_true;
    logic strobe_two_true;
    logic strobe_one_inverted;
    logic strobe_two_inverted;
  } siopm_periph_s;
  typedef enum logic [1:0] {
    SIOPM_W_IDLE = 2'b00,
    SIOPM_W_RESP = 2'b01
  } siopm_wstate_e;
endpackage

// ===== logic/siopm_pin_cell.sv
module siopm_pin_cell
  import siopm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pad_in,
  input wire logic out_value,
  input wire logic dir_out,
  input wire logic mode_periph,
  input wire logic [1:0] sel,
  input wire logic [3:0] src,
  output logic pad_out,
  output logic pad_oe,
  output logic sync_level
);
  logic sync_first;
  logic next_sync_first;
  logic next_sync_level;
  logic periph_bit;

  always_comb begin
    next_sync_first = pad_in;
    next_sync_level = sync_first;
    periph_bit = src[sel];
  end

  // Two-stage synchronizer ahead of readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_first <= 1'b0;
      sync_level <= 1'b0;
    end else begin
      sync_first <= next_sync_first;
      sync_level <= next_sync_level;
    end
  end

  // Peripheral mode always drives
  assign pad_oe = mode_periph | dir_out;
  assign pad_out = mode_periph ? periph_bit : out_value;
endmodule // siopm_pin_cell

// ===== logic/siopm_top.sv
`include "siopm_defines.svh"
// Operation
// - Each pin is general input, general output or peripheral output.
// - Three 16-pin ports, each with its own register set of identical layout; peripheral sources differ by port.
// - General output drives the output value bit onto the pin.
// - Readback register returns level of all 16 pins, two clocks late through the two-stage synchronizer.
// - In mode 0, direction 0 leaves pin undriven input, 1 makes it output; mode 1 always drives.
// - Mode 0 uses general controls, mode 1 selects peripheral source.
// - Low select register holds 2-bit selectors for pins 0 to 7.
// - High select register holds 2-bit selectors for pins 8 to 15.
// - Codes 10 and 11 drive matching bit of first or second queue word.
// - Port 1 code 00 puts queue empty flags on pins 6 and 7.
// - Port 2 code 00 routes both modulators' phase pairs to pins 0-15.
// - Port 2 code 01 routes counters to pins 2-7, rate generators to 8-11.
// - Port 2 code 01 routes strobes to pins 12 to 15.
// - All selector, output, direction and mode fields reset to zero.
module siopm_top
  import siopm_pkg::*;
#(
  parameter int NUM_PORTS = `SIOPM_NUM_PORTS,
  parameter int PORT_W = `SIOPM_PORT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire siopm_periph_s periph,
  input wire logic [47:0] pin_bits_in,
  output logic [47:0] pin_bits_out,
  output logic [47:0] pin_bits_oe
);
  // Logic below is written for three 16-bit ports only
  if (NUM_PORTS != 3 || PORT_W != 16) begin : g_bad_params
    $error("siopm_top supports only three 16-bit ports");
  end

  siopm_port_cfg_s cfg [3];
  siopm_port_cfg_s next_cfg [3];
  logic [47:0] sync_levels;

  // Write channel state
  logic aw_held;
  logic next_aw_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  // Read channel state
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  logic do_write;
  logic [1:0] wport;
  logic [7:0] woff;
  logic wport_ok;
  logic [1:0] rport;
  logic [7:0] roff;
  logic rport_ok;
  logic [15:0] wmask;
  logic [15:0] rword;
  logic rhit;

  // Port number from address bits 6:5
  function automatic logic [1:0] port_of(input logic [7:0] a);
    port_of = a[6:5];
  endfunction

  // Byte-lane merge of a write into a field
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nv & m);
  endfunction

  // No new write address or data while a response waits
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // Write path: address and data may arrive in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !bvalid;
    wport = port_of(aw_addr);
    woff = aw_addr & 8'h1f;
    // Unmapped, misaligned or out-of-range writes get SLVERR
    wport_ok = (wport < 2'd3) && !aw_addr[7] && (aw_addr[1:0] == 2'b00)
               && (woff <= `SIOPM_OFF_SELECT_HIGH);
    // Only the two low strobes matter; upper lanes hold nothing
    wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wport_ok ? 2'b00 : 2'b10;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Per-port register file
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      next_cfg[p] = cfg[p];
      if (do_write && wport_ok && wport == p[1:0]) begin
        case (woff)
          `SIOPM_OFF_OUTPUT_VALUE: begin
            next_cfg[p].output_value = merge(cfg[p].output_value, w_data[15:0], wmask);
          end
          `SIOPM_OFF_DIRECTION: begin
            next_cfg[p].direction = merge(cfg[p].direction, w_data[15:0], wmask);
          end
          `SIOPM_OFF_PIN_MODE: begin
            next_cfg[p].pin_mode = merge(cfg[p].pin_mode, w_data[15:0], wmask);
          end
          `SIOPM_OFF_SELECT_LOW: begin
            next_cfg[p].select_low = merge(cfg[p].select_low, w_data[15:0], wmask);
          end
          `SIOPM_OFF_SELECT_HIGH: begin
            next_cfg[p].select_high = merge(cfg[p].select_high, w_data[15:0], wmask);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read path
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    rport = port_of(s_axi_araddr);
    roff = s_axi_araddr & 8'h1f;
    // Unmapped reads return zero with SLVERR
    rport_ok = (rport < 2'd3) && !s_axi_araddr[7] && (s_axi_araddr[1:0] == 2'b00);
    rhit = 1'b1;
    rword = 16'h0000;
    if (rport_ok) begin
      case (roff)
        `SIOPM_OFF_OUTPUT_VALUE: rword = cfg[rport].output_value;
        `SIOPM_OFF_PIN_READBACK: rword = sync_levels[rport*16 +: 16];
        `SIOPM_OFF_DIRECTION: rword = cfg[rport].direction;
        `SIOPM_OFF_PIN_MODE: rword = cfg[rport].pin_mode;
        `SIOPM_OFF_SELECT_LOW: rword = cfg[rport].select_low;
        `SIOPM_OFF_SELECT_HIGH: rword = cfg[rport].select_high;
        default: rhit = 1'b0;
      endcase
    end else begin
      rhit = 1'b0;
    end
    // Capture read data when the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, rword};
      next_rresp = rhit ? 2'b00 : 2'b10;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus channel and config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
      for (int p = 0; p < 3; p++) begin
        cfg[p] <= '{`SIOPM_RESET_VALUE, `SIOPM_RESET_VALUE, `SIOPM_RESET_VALUE,
                    `SIOPM_RESET_VALUE, `SIOPM_RESET_VALUE};
      end
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      for (int p = 0; p < 3; p++) begin
        cfg[p] <= next_cfg[p];
      end
    end
  end

  // Per-pin source table, index = selector code
  genvar gp, gb;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_port
      for (gb = 0; gb < 16; gb++) begin : g_bit
        logic [1:0] sel;
        logic [3:0] src;
        logic code00;
        logic code01;
        // Selector fields
        assign sel = (gb < 8) ? cfg[gp].select_low[2*(gb%8) +: 2]
                              : cfg[gp].select_high[2*(gb%8) +: 2];
        if (gp == 1 && gb == 6) begin : g_e0
          assign code00 = periph.first_queue_empty_flag;
        end else if (gp == 1 && gb == 7) begin : g_e1
          assign code00 = periph.second_queue_empty_flag;
        end else if (gp == 2) begin : g_mod
          assign code00 = periph.modulator_phases[gb];
        end else begin : g_z0
          assign code00 = 1'b0;
        end
        if (gp == 2 && gb >= 2 && gb <= 7) begin : g_cnt
          assign code01 = periph.counter_outputs[gb-2];
        end else if (gp == 2 && gb >= 8 && gb <= 11) begin : g_rate
          assign code01 = periph.rate_generator_outputs[gb-8];
        end else if (gp == 2 && gb == 12) begin : g_s1
          assign code01 = periph.strobe_one_true;
        end else if (gp == 2 && gb == 13) begin : g_s2
          assign code01 = periph.strobe_two_true;
        end else if (gp == 2 && gb == 14) begin : g_s1n
          assign code01 = periph.strobe_one_inverted;
        end else if (gp == 2 && gb == 15) begin : g_s2n
          assign code01 = periph.strobe_two_inverted;
        end else begin : g_z1
          assign code01 = 1'b0;
        end
        // Queue words on every pin
        assign src = {periph.second_queue_word[gb], periph.first_queue_word[gb],
                      code01, code00};
        siopm_pin_cell u_cell (
          .aclk(aclk),
          .aresetn(aresetn),
          .pad_in(pin_bits_in[gp*16+gb]),
          .out_value(cfg[gp].output_value[gb]),
          .dir_out(cfg[gp].direction[gb]),
          .mode_periph(cfg[gp].pin_mode[gb]),
          .sel(sel),
          .src(src),
          .pad_out(pin_bits_out[gp*16+gb]),
          .pad_oe(pin_bits_oe[gp*16+gb]),
          .sync_level(sync_levels[gp*16+gb])
        );
      end
    end
  endgenerate
endmodule // siopm_top

// ===== bench/siopm_props.sv
module siopm_props
  import siopm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [47:0] pin_bits_out,
  input wire logic [47:0] pin_bits_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_stall;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_closes: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_closes: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_reset_quiet: assert property ($rose(aresetn) |-> pin_bits_oe == '0 && pin_bits_out == '0)
    else $error("pins driven after reset");
  a_oe_on_commit: assert property (!$stable(pin_bits_oe) |-> $rose(s_axi_bvalid))
    else $error("drive changed without write");
endmodule // siopm_props

bind siopm_top siopm_props i_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .pin_bits_out, .pin_bits_oe);

// ===== bench/siopm_pins.sv
module siopm_pins (
  input wire logic [47:0] pin_bits_out,
  input wire logic [47:0] pin_bits_oe,
  input wire logic [47:0] ext_val,
  output logic [47:0] pin_bits_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside drivers yield wherever the block drives
  assign pin_bits_in = (pin_bits_oe & pin_bits_out) | (~pin_bits_oe & ext_val);
endmodule // siopm_pins

// ===== bench/siopm_bench.sv
module siopm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import siopm_pkg::*;
  logic aclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rdd;
  logic [3:0] ws = 4'hf;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrr, bv, arr, rv;
  logic [1:0] br, rr;
  siopm_periph_s per = '0;
  logic [47:0] pin_in, pout, poe, xv = 48'h0;
  logic [15:0] mdl [3][6];
  logic [33:0] exp_q [$];
  logic [31:0] seed = 32'd98668;
  int errors = 0, check_count = 0, cyc = 0;
  always #25 aclk = ~aclk;
  siopm_top i_dut (.aclk, .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .periph(per), .pin_bits_in(pin_in), .pin_bits_out(pout),
    .pin_bits_oe(poe));
  siopm_pins i_pins (.pin_bits_out(pout), .pin_bits_oe(poe), .ext_val(xv),
    .pin_bits_in(pin_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_bus(string n, logic [33:0] e, logic [33:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_pin(string n, logic [47:0] e, logic [47:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d, logic [3:0] s, logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    awa <= a;
    wd <= {16'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (!(bv && bry));
  endtask
  task automatic rd(logic [7:0] a, logic [33:0] e);
    exp_q.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!(rv && rry));
  endtask
  // Response checker, oldest note first
  always @(posedge aclk) begin
    if (bv && bry) chk_bus("bresp", exp_q.pop_front(), {br, 32'h0});
    if (rv && rry) chk_bus("rdata", exp_q.pop_front(), {rr, rdd});
  end
  function automatic logic [1:0] pexp(int p, int n);
    logic [15:0] s;
    logic [13:0] alt;
    logic v;
    s = mdl[p][n / 8 + 4];
    alt = {per.strobe_two_inverted, per.strobe_one_inverted, per.strobe_two_true,
      per.strobe_one_true, per.rate_generator_outputs, per.counter_outputs};
    if (!mdl[p][3][n]) return {2{mdl[p][2][n]}} & {1'b1, mdl[p][0][n]};
    case (s[2 * (n % 8) +: 2])
      2'b10: v = per.first_queue_word[n];
      2'b11: v = per.second_queue_word[n];
      2'b00: v = p == 1 ? (n == 6 ? per.first_queue_empty_flag :
        n == 7 && per.second_queue_empty_flag) : p == 2 && per.modulator_phases[n];
      default: v = p == 2 && n > 1 && alt[n - 2];
    endcase
    return {1'b1, v};
  endfunction
  task automatic pins();
    logic [47:0] eo, ev, rb;
    for (int i = 0; i < 48; i++) {eo[i], ev[i]} = pexp(i / 16, i % 16);
    chk_pin("pin_oe", eo, poe);
    chk_pin("pin_out", ev, pout & poe);
    rb = (eo & ev) | (~eo & xv);
    repeat (3) @(posedge aclk);
    for (int p = 0; p < 3; p++) rd(8'(p * 32 + 4), {18'h0, rb[16 * p +: 16]});
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    xv <= 48'h0;
    repeat (20) @(posedge aclk);
    rstn <= 1'b1;
    foreach (mdl[p, k]) mdl[p][k] = 16'h0;
    @(posedge aclk);
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 6; k++) rd(8'(p * 32 + k * 4), 34'h0);
    pins();
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    do_reset();
    for (int it = 0; it < 40; it++) begin
      int p;
      logic [15:0] d, m;
      logic [3:0] s;
      p = int'(rnd() % 3);
      per <= siopm_periph_s'({rnd(), rnd()});
      xv <= 48'({rnd(), rnd()});
      for (int k = 0; k < 6; k++) begin
        d = 16'(rnd());
        s = it < 4 ? 4'hf : 4'(rnd());
        m = {{8{s[1]}}, {8{s[0]}}};
        wr(8'(p * 32 + k * 4), d, s, 2'b00);
        if (k != 1) mdl[p][k] = (mdl[p][k] & ~m) | (d & m);
      end
      pins();
      for (int k = 0; k < 6; k++) if (k != 1) rd(8'(p * 32 + k * 4), {18'h0, mdl[p][k]});
    end
    wr(8'h60, 16'hffff, 4'hf, 2'b10);
    rd(8'h18, {2'b10, 32'h0});
    rd(8'h82, {2'b10, 32'h0});
    do_reset();
    finish_test();
  end
endmodule // siopm_bench
